// ---- src/voice_gain_pkg.sv ----
// Purpose: Shared constants for the voice path digital gain block.
// Assumes: Gain factors are unsigned fixed point with GAIN_FRAC_BITS.
// Notes: Register index times four gives the APB byte address.
package voice_gain_pkg;
   // Register indices and their byte addresses
   localparam logic [7:0] TX_COARSE_IDX = 8'h26;
   localparam logic [7:0] RX_COARSE_IDX = 8'h27;
   localparam logic [7:0] TX_FINE_IDX = 8'h28;
   localparam logic [7:0] RX_FINE_IDX = 8'h29;
   localparam logic [7:0] TX_COARSE_ADDR = {TX_COARSE_IDX[5:0], 2'b00};
   localparam logic [7:0] RX_COARSE_ADDR = {RX_COARSE_IDX[5:0], 2'b00};
   localparam logic [7:0] TX_FINE_ADDR = {TX_FINE_IDX[5:0], 2'b00};
   localparam logic [7:0] RX_FINE_ADDR = {RX_FINE_IDX[5:0], 2'b00};

   // Field layout of each gain register
   localparam int DIR_POS = 4;
   localparam int CFG_W = 5;
   localparam logic [4:0] GAIN_RST = 5'h00;

   // Fixed point format and datapath latency
   localparam int GAIN_W = 18;
   localparam int GAIN_FRAC_BITS = 14;
   localparam int PATH_LATENCY = 2;
   localparam logic [3:0] COARSE_GAIN_LIMIT = 4'hc;

   // Unity, then one entry per dB of coarse gain
   localparam logic [17:0] COARSE_GAIN_TBL [0:12] = '{
      18'd16384, 18'd18383, 18'd20626, 18'd23143, 18'd25967, 18'd29135,
      18'd32690, 18'd36679, 18'd41155, 18'd46176, 18'd51811, 18'd58133,
      18'd65226};
   // Unity, then one entry per dB of coarse attenuation
   localparam logic [17:0] COARSE_ATTEN_TBL [0:15] = '{
      18'd16384, 18'd14602, 18'd13014, 18'd11599, 18'd10338, 18'd9213,
      18'd8211, 18'd7318, 18'd6523, 18'd5813, 18'd5181, 18'd4618,
      18'd4115, 18'd3668, 18'd3269, 18'd2914};
   // Unity, then one entry per 0.1 dB of fine gain
   localparam logic [17:0] FINE_GAIN_TBL [0:15] = '{
      18'd16384, 18'd16574, 18'd16766, 18'd16960, 18'd17156, 18'd17355,
      18'd17556, 18'd17759, 18'd17965, 18'd18173, 18'd18383, 18'd18596,
      18'd18811, 18'd19029, 18'd19250, 18'd19472};
   // Unity, then one entry per 0.1 dB of fine attenuation
   localparam logic [17:0] FINE_ATTEN_TBL [0:15] = '{
      18'd16384, 18'd16196, 18'd16011, 18'd15828, 18'd15647, 18'd15467,
      18'd15290, 18'd15115, 18'd14942, 18'd14771, 18'd14602, 18'd14435,
      18'd14270, 18'd14107, 18'd13945, 18'd13785};
endpackage : voice_gain_pkg

// ---- src/gain_stage.sv ----
// Purpose: One gain or attenuation stage, sample times table factor.
// Assumes: Samples are two's complement, one per valid strobe.
// Notes: One cycle of latency; result rounds and saturates.
module gain_stage
   import voice_gain_pkg::*;
#(
   parameter int DW = 16,
   parameter bit FINE = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [DW-1:0] i_data,
   input wire logic i_dir,
   input wire logic [3:0] i_code,
   output logic o_valid,
   output logic [DW-1:0] o_data,
   output logic [GAIN_W-1:0] o_factor
);
   localparam int PW = DW + GAIN_W + 1;
   localparam int SW = PW - GAIN_FRAC_BITS;
   localparam logic [PW-1:0] ROUND = PW'(1) << (GAIN_FRAC_BITS - 1);
   localparam logic signed [SW-1:0] MAXV = SW'((1 << (DW - 1)) - 1);
   localparam logic signed [SW-1:0] MINV = -SW'(1 << (DW - 1));

   logic signed [PW-1:0] prod;
   logic signed [SW-1:0] scaled;
   logic [DW-1:0] sat_nxt;

   // Factor lookup; code zero maps to unity in every table
   always_comb begin
      if (FINE && i_dir) begin
         o_factor = FINE_ATTEN_TBL[i_code];
      end else if (FINE) begin
         o_factor = FINE_GAIN_TBL[i_code];
      end else if (i_dir) begin
         o_factor = COARSE_ATTEN_TBL[i_code];
      end else if (i_code[3:2] == 2'b11) begin
         o_factor = COARSE_GAIN_TBL[COARSE_GAIN_LIMIT]; // Gain clamps here
      end else begin
         o_factor = COARSE_GAIN_TBL[i_code];
      end
   end

   // Multiply, round to nearest, then clamp to the sample range
   always_comb begin
      prod = $signed(i_data) * $signed({1'b0, o_factor});
      scaled = SW'((prod + $signed(ROUND)) >>> GAIN_FRAC_BITS);
      if (scaled > MAXV) begin
         sat_nxt = MAXV[DW-1:0];
      end else if (scaled < MINV) begin
         sat_nxt = MINV[DW-1:0];
      end else begin
         sat_nxt = scaled[DW-1:0];
      end
   end

   // Output register; data held between strobes
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
         o_data <= '0;
      end else begin
         o_valid <= i_valid;
         if (i_valid) begin
            o_data <= sat_nxt;
         end
      end
   end
endmodule : gain_stage

// ---- src/voice_path_digital_gain.sv ----
// Purpose: Transmit and receive voice path gain, set over APB.
// Assumes: Samples come from logic on I_MCLK; no synchroniser needed.
// Notes: Coarse then fine stage per path, two cycles from in to out.
// Notes: Zero wait state slave; unmapped access answers with PSLVERR.
//
// Decided for this implementation: the APB slave port.

module voice_path_digital_gain
   import voice_gain_pkg::*;
#(
   parameter int DW = 16
) (
   input wire logic I_MCLK,
   input wire logic I_RSTN,
   input wire logic i_PSEL,
   input wire logic i_PENABLE,
   input wire logic i_PWRITE,
   input wire logic [7:0] i_PADDR,
   input wire logic [31:0] i_PWDATA,
   output logic [31:0] o_PRDATA,
   output logic o_PREADY,
   output logic o_PSLVERR,
   input wire logic i_TX_VALID,
   input wire logic [DW-1:0] i_TX_DATA,
   output logic o_TX_VALID,
   output logic [DW-1:0] o_TX_DATA,
   input wire logic i_RX_VALID,
   input wire logic [DW-1:0] i_RX_DATA,
   output logic o_RX_VALID,
   output logic [DW-1:0] o_RX_DATA
);
   logic [CFG_W-1:0] tx_coarse_r;
   logic [CFG_W-1:0] rx_coarse_r;
   logic [CFG_W-1:0] tx_fine_r;
   logic [CFG_W-1:0] rx_fine_r;
   logic [31:0] rdata_nxt;
   logic hit;
   logic setup;
   logic access;
   logic wr_en;
   logic tx_coarse_direction;
   logic [3:0] tx_coarse_code;
   logic rx_coarse_direction;
   logic [3:0] rx_coarse_code;
   logic tx_fine_direction;
   logic [3:0] tx_fine_code;
   logic rx_fine_direction;
   logic [3:0] rx_fine_code;

   // Per path wiring: index 0 transmit, index 1 receive
   logic in_valid [2];
   logic [DW-1:0] in_data [2];
   logic mid_valid [2];
   logic [DW-1:0] mid_data [2];
   logic out_valid [2];
   logic [DW-1:0] out_data [2];
   logic coarse_dir [2];
   logic [3:0] coarse_code [2];
   logic fine_dir [2];
   logic [3:0] fine_code [2];
   logic [GAIN_W-1:0] coarse_factor [2];
   logic [GAIN_W-1:0] fine_factor [2];

   // Field split of the four gain registers
   assign tx_coarse_direction = tx_coarse_r[DIR_POS];
   assign tx_coarse_code = tx_coarse_r[3:0];
   assign rx_coarse_direction = rx_coarse_r[DIR_POS];
   assign rx_coarse_code = rx_coarse_r[3:0];
   assign tx_fine_direction = tx_fine_r[DIR_POS];
   assign tx_fine_code = tx_fine_r[3:0];
   assign rx_fine_direction = rx_fine_r[DIR_POS];
   assign rx_fine_code = rx_fine_r[3:0];

   // APB phase decode
   assign setup = i_PSEL && !i_PENABLE;
   assign access = i_PSEL && i_PENABLE;
   assign hit = (i_PADDR == TX_COARSE_ADDR) || (i_PADDR == RX_COARSE_ADDR)
      || (i_PADDR == TX_FINE_ADDR) || (i_PADDR == RX_FINE_ADDR);
   assign wr_en = access && i_PWRITE && hit;

   // Zero wait states keep the master's hold time to one access cycle
   assign o_PREADY = 1'b1;
   assign o_PSLVERR = access && !hit;

   // Gain register writes; only the low five bits are stored
   always_ff @(posedge I_MCLK) begin
      if (!I_RSTN) begin
         tx_coarse_r <= GAIN_RST;
         rx_coarse_r <= GAIN_RST;
         tx_fine_r <= GAIN_RST;
         rx_fine_r <= GAIN_RST;
      end else if (wr_en) begin
         case (i_PADDR)
            TX_COARSE_ADDR: tx_coarse_r <= i_PWDATA[CFG_W-1:0];
            RX_COARSE_ADDR: rx_coarse_r <= i_PWDATA[CFG_W-1:0];
            TX_FINE_ADDR: tx_fine_r <= i_PWDATA[CFG_W-1:0];
            RX_FINE_ADDR: rx_fine_r <= i_PWDATA[CFG_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Read mux; reserved bits and unmapped addresses read zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (i_PADDR)
         TX_COARSE_ADDR: rdata_nxt[CFG_W-1:0] = tx_coarse_r;
         RX_COARSE_ADDR: rdata_nxt[CFG_W-1:0] = rx_coarse_r;
         TX_FINE_ADDR: rdata_nxt[CFG_W-1:0] = tx_fine_r;
         RX_FINE_ADDR: rdata_nxt[CFG_W-1:0] = rx_fine_r;
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Read data captured in setup so it stands through the access cycle
   always_ff @(posedge I_MCLK) begin
      if (!I_RSTN) begin
         o_PRDATA <= 32'h0000_0000;
      end else if (setup && !i_PWRITE) begin
         o_PRDATA <= rdata_nxt;
      end
   end

   // Path inputs and settings, gathered for the generate loop
   assign in_valid[0] = i_TX_VALID;
   assign in_data[0] = i_TX_DATA;
   assign in_valid[1] = i_RX_VALID;
   assign in_data[1] = i_RX_DATA;
   assign coarse_dir[0] = tx_coarse_direction;
   assign coarse_code[0] = tx_coarse_code;
   assign coarse_dir[1] = rx_coarse_direction;
   assign coarse_code[1] = rx_coarse_code;
   assign fine_dir[0] = tx_fine_direction;
   assign fine_code[0] = tx_fine_code;
   assign fine_dir[1] = rx_fine_direction;
   assign fine_code[1] = rx_fine_code;

   // Coarse stage feeds fine stage, so the two dB settings add
   for (genvar p = 0; p < 2; p++) begin : g_path
      gain_stage #(.DW(DW), .FINE(1'b0)) u_coarse (
         .i_clk(I_MCLK),
         .i_rst_n(I_RSTN),
         .i_valid(in_valid[p]),
         .i_data(in_data[p]),
         .i_dir(coarse_dir[p]),
         .i_code(coarse_code[p]),
         .o_valid(mid_valid[p]),
         .o_data(mid_data[p]),
         .o_factor(coarse_factor[p])
      );
      gain_stage #(.DW(DW), .FINE(1'b1)) u_fine (
         .i_clk(I_MCLK),
         .i_rst_n(I_RSTN),
         .i_valid(mid_valid[p]),
         .i_data(mid_data[p]),
         .i_dir(fine_dir[p]),
         .i_code(fine_code[p]),
         .o_valid(out_valid[p]),
         .o_data(out_data[p]),
         .o_factor(fine_factor[p])
      );
   end

   // Path outputs come straight from the fine stage registers
   assign o_TX_VALID = out_valid[0];
   assign o_TX_DATA = out_data[0];
   assign o_RX_VALID = out_valid[1];
   assign o_RX_DATA = out_data[1];

   // Transmit coarse gain rises with the code in gain mode, except between 11xx codes, which hold the 12 dB clamp
   property p_tx_coarse_gain_up;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (!tx_coarse_direction && !$past(tx_coarse_direction)
         && tx_coarse_code > $past(tx_coarse_code))
      |-> coarse_factor[0] > $past(coarse_factor[0])
         || tx_coarse_code[3:2] == 2'b11;
   endproperty
   a_tx_coarse_gain_up: assert property (p_tx_coarse_gain_up)
      else $error("tx coarse gain did not rise with code");

   // Transmit coarse attenuation deepens with the code
   property p_tx_coarse_atten_up;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (tx_coarse_direction && $past(tx_coarse_direction)
         && tx_coarse_code > $past(tx_coarse_code))
      |-> coarse_factor[0] < $past(coarse_factor[0]);
   endproperty
   a_tx_coarse_atten_up: assert property (p_tx_coarse_atten_up)
      else $error("tx coarse attenuation did not deepen with code");

   // Gain codes 11xx all land on the 12 dB factor
   property p_tx_coarse_clamp;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (!tx_coarse_direction && tx_coarse_code[3:2] == 2'b11)
      |-> coarse_factor[0] == 18'd65226;
   endproperty
   a_tx_coarse_clamp: assert property (p_tx_coarse_clamp)
      else $error("tx coarse 11xx is not 12 dB");

   // Attenuation end points: 1 dB at 0001, 15 dB at 1111
   property p_tx_coarse_atten_ends;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      tx_coarse_direction
      |-> (tx_coarse_code != 4'hf || coarse_factor[0] == 18'd2914)
         && (tx_coarse_code != 4'h1 || coarse_factor[0] == 18'd14602);
   endproperty
   a_tx_coarse_atten_ends: assert property (p_tx_coarse_atten_ends)
      else $error("tx coarse attenuation end point wrong");

   // Zero codes pass samples through unchanged after two cycles
   property p_tx_unity;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (i_TX_VALID && !wr_en && tx_coarse_code == 4'h0
         && tx_fine_code == 4'h0) ##1 !wr_en
      |=> o_TX_VALID && o_TX_DATA == $past(i_TX_DATA, 2);
   endproperty
   a_tx_unity: assert property (p_tx_unity)
      else $error("zero code did not give 0 dB");

   // Receive coarse factor follows code and direction
   property p_rx_coarse_steps;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      ({1'b0, rx_coarse_code} == {1'b0, $past(rx_coarse_code)} + 5'h01
         && rx_coarse_direction == $past(rx_coarse_direction))
      |-> (rx_coarse_direction
            ? coarse_factor[1] < $past(coarse_factor[1])
            : (coarse_factor[1] > $past(coarse_factor[1])
               || rx_coarse_code[3:2] == 2'b11));
   endproperty
   a_rx_coarse_steps: assert property (p_rx_coarse_steps)
      else $error("rx coarse step went the wrong way");

   // Receive coarse limits and 11xx clamp
   property p_rx_coarse_limits;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (rx_coarse_code[3:2] == 2'b11)
      |-> coarse_factor[1] == (rx_coarse_direction
         ? COARSE_ATTEN_TBL[rx_coarse_code] : 18'd65226);
   endproperty
   a_rx_coarse_limits: assert property (p_rx_coarse_limits)
      else $error("rx coarse limit factor wrong");

   // Transmit fine stage: 0.1 dB table, 1.5 dB at full code
   property p_tx_fine;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (tx_fine_code == 4'hf)
      |-> fine_factor[0] == (tx_fine_direction ? 18'd13785 : 18'd19472);
   endproperty
   a_tx_fine: assert property (p_tx_fine)
      else $error("tx fine full scale factor wrong");

   // Receive fine stage takes one 0.1 dB table step at code 0001, either direction
   property p_rx_fine;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (rx_fine_code == 4'h1)
      |-> fine_factor[1] == (rx_fine_direction ? 18'd16196 : 18'd16574);
   endproperty
   a_rx_fine: assert property (p_rx_fine)
      else $error("rx fine 0.1 dB factor wrong");

   // Both stages in line: a sample emerges exactly two cycles later
   property p_cascade_latency;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      i_RX_VALID |-> ##1 !o_RX_VALID || $past(i_RX_VALID, 2) ##1 o_RX_VALID;
   endproperty
   a_cascade_latency: assert property (p_cascade_latency)
      else $error("rx sample did not emerge after two cycles");

   // Reads of gain registers never show the upper bits
   property p_reserved_zero;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (setup && !i_PWRITE && hit) |=> o_PRDATA[31:CFG_W] == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved gain bits read nonzero");

   // Transmit samples also emerge exactly two cycles later
   property p_tx_latency;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      i_TX_VALID |-> ##1 !o_TX_VALID || $past(i_TX_VALID, 2) ##1 o_TX_VALID;
   endproperty
   a_tx_latency: assert property (p_tx_latency)
      else $error("tx sample did not emerge after two cycles");

   // No result strobe without a sample two cycles before it
   property p_no_stray_valid;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (o_TX_VALID || o_RX_VALID)
      |-> (!o_TX_VALID || $past(i_TX_VALID, 2))
         && (!o_RX_VALID || $past(i_RX_VALID, 2));
   endproperty
   a_no_stray_valid: assert property (p_no_stray_valid)
      else $error("result strobe without a sample");

   // Zero receive codes pass samples through unchanged
   property p_rx_unity;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (i_RX_VALID && !wr_en && rx_coarse_code == 4'h0
         && rx_fine_code == 4'h0) ##1 !wr_en
      |=> o_RX_VALID && o_RX_DATA == $past(i_RX_DATA, 2);
   endproperty
   a_rx_unity: assert property (p_rx_unity)
      else $error("zero rx code did not give 0 dB");

   // Unmapped writes leave every gain register alone
   property p_unmapped_write;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (access && i_PWRITE && !hit)
      |=> $stable(tx_coarse_r) && $stable(rx_coarse_r)
         && $stable(tx_fine_r) && $stable(rx_fine_r);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write)
      else $error("unmapped write changed a gain register");

   // A transmit fine write keeps only the five low data bits
   property p_write_lands;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (wr_en && i_PADDR == TX_FINE_ADDR)
      |=> tx_fine_r == $past(i_PWDATA[CFG_W-1:0]);
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("tx fine write did not land");

   // Receive fine stage reaches 1.5 dB at full code
   property p_rx_fine_full;
      @(posedge I_MCLK) disable iff (!I_RSTN)
      (rx_fine_code == 4'hf)
      |-> fine_factor[1] == (rx_fine_direction ? 18'd13785 : 18'd19472);
   endproperty
   a_rx_fine_full: assert property (p_rx_fine_full)
      else $error("rx fine full scale factor wrong");
endmodule : voice_path_digital_gain

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the voice path gain block.
// Assumes: Zero wait state APB slave; gain registers reset to zero.
// Notes: Expected levels come from dB settings, not from the tables.
module tb_top
   import voice_gain_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic [4:0] tc;
      logic [4:0] tf;
      logic [4:0] rc;
      logic [4:0] rf;
      logic [15:0] s;
   } row_t;

   logic mclk = 1'b0;
   logic rst_n;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic tx_in_valid, rx_in_valid, tx_out_valid, rx_out_valid;
   logic [15:0] tx_in_data, rx_in_data, tx_out_data, rx_out_data;
   logic [15:0] txq [$];
   logic [7:0] addrs [4] = '{TX_COARSE_ADDR, RX_COARSE_ADDR,
      TX_FINE_ADDR, RX_FINE_ADDR};
   // Settings per row: tx coarse, tx fine, rx coarse, rx fine, sample
   row_t rows [8] = '{
      '{5'h01, 5'h00, 5'h0c, 5'h00, 16'h1000},
      '{5'h0b, 5'h0f, 5'h0f, 5'h1f, 16'h1000},
      '{5'h0c, 5'h00, 5'h01, 5'h01, 16'h0800},
      '{5'h0f, 5'h0f, 5'h0d, 5'h0f, 16'h7000},
      '{5'h11, 5'h01, 5'h1f, 5'h10, 16'hc000},
      '{5'h1f, 5'h1f, 5'h11, 5'h0a, 16'h8001},
      '{5'h10, 5'h10, 5'h10, 5'h10, 16'h5555},
      '{5'h17, 5'h05, 5'h06, 5'h19, 16'hfff0}};
   int mismatches = 0;
   int total_checks = 0;

   // 40 MHz clock
   always #12.5 mclk = ~mclk;

   voice_path_digital_gain #(.DW(16)) dut (
      .I_MCLK(mclk), .I_RSTN(rst_n), .i_PSEL(psel),
      .i_PENABLE(penable), .i_PWRITE(pwrite), .i_PADDR(paddr),
      .i_PWDATA(pwdata), .o_PRDATA(prdata), .o_PREADY(pready),
      .o_PSLVERR(pslverr), .i_TX_VALID(tx_in_valid),
      .i_TX_DATA(tx_in_data), .o_TX_VALID(tx_out_valid),
      .o_TX_DATA(tx_out_data), .i_RX_VALID(rx_in_valid),
      .i_RX_DATA(rx_in_data), .o_RX_VALID(rx_out_valid),
      .o_RX_DATA(rx_out_data));

   // Collect every transmit result; catches back-to-back output strobes
   always @(posedge mclk) begin
      if (tx_out_valid === 1'b1)
         txq.push_back(tx_out_data);
   end

   task give_verdict;
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   task check(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One APB transfer; waits for pready, bounded by the watchdog
   task apb(input logic wr, input logic [7:0] addr,
         input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rdchk(input string what, input logic [7:0] addr,
         input logic [31:0] exp, input logic eerr);
      logic [31:0] d;
      logic e;
      apb(1'b0, addr, 32'h0, d, e);
      check(what, exp, d);
      check({what, " err"}, {31'h0, eerr}, {31'h0, e});
   endtask : rdchk

   task wr(input logic [7:0] addr, input logic [4:0] v);
      logic [31:0] d;
      logic e;
      // Junk in the upper bits must not stick
      apb(1'b1, addr, {27'h2aaaaaa, v}, d, e);
   endtask : wr

   // Present one sample on both paths and return the results
   task send(input logic [15:0] tx, rx, output logic [15:0] otx, orx);
      int n;
      @(posedge mclk);
      tx_in_valid <= 1'b1;
      rx_in_valid <= 1'b1;
      tx_in_data <= tx;
      rx_in_data <= rx;
      @(posedge mclk);
      tx_in_valid <= 1'b0;
      rx_in_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (tx_out_valid !== 1'b1 && n < 8);
      check("tx valid", 32'h1, {31'h0, tx_out_valid});
      check("rx valid", 32'h1, {31'h0, rx_out_valid});
      otx = tx_out_data;
      orx = rx_out_data;
      @(posedge mclk);
      #1;
      check("tx valid drop", 32'h0, {31'h0, tx_out_valid});
      check("tx hold", {16'h0, otx}, {16'h0, tx_out_data});
      check("rx valid drop", 32'h0, {31'h0, rx_out_valid});
   endtask : send

   // Rounded Q4.14 stage, saturating to 16 bits
   function automatic logic [15:0] scale(logic [15:0] x, real db);
      longint f;
      longint y;
      f = longint'($floor($pow(10.0, db / 20.0) * 16384.0 + 0.5));
      y = (longint'($signed(x)) * f + 8192) >>> 14;
      if (y > 32767)
         y = 32767;
      if (y < -32768)
         y = -32768;
      return y[15:0];
   endfunction : scale

   function automatic real cdb(logic [4:0] r);
      if (r[4])
         return -real'(r[3:0]);
      return (r[3:0] >= 4'hc) ? 12.0 : real'(r[3:0]);
   endfunction : cdb

   function automatic real fdb(logic [4:0] r);
      return (r[4] ? -0.1 : 0.1) * real'(r[3:0]);
   endfunction : fdb

   // Hang guard, about five times the length of a clean run
   initial begin
      #100000;
      mismatches++;
      give_verdict;
   end

   initial begin
      logic [15:0] otx, orx, ex;
      logic [4:0] v [4];
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tx_in_valid = 1'b0;
      rx_in_valid = 1'b0;
      tx_in_data = 16'h0;
      rx_in_data = 16'h0;
      rst_n = 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      // Ordinary cases: program, read back, pass a sample each way
      foreach (rows[i]) begin
         v = '{rows[i].tc, rows[i].rc, rows[i].tf, rows[i].rf};
         for (int j = 0; j < 4; j++)
            wr(addrs[j], v[j]);
         for (int j = 0; j < 4; j++)
            rdchk("gain reg", addrs[j], {27'h0, v[j]}, 1'b0);
         send(rows[i].s, ~rows[i].s, otx, orx);
         ex = scale(scale(rows[i].s, cdb(rows[i].tc)), fdb(rows[i].tf));
         check("tx out", 32'(ex), 32'(otx));
         ex = scale(scale(~rows[i].s, cdb(rows[i].rc)), fdb(rows[i].rf));
         check("rx out", 32'(ex), 32'(orx));
      end
      // Sweep every code in both directions, one step at a time
      for (int k = 0; k < 32; k++) begin
         for (int j = 0; j < 4; j++)
            wr(addrs[j], 5'(k));
         send(16'h2000, 16'hdfff, otx, orx);
         ex = scale(scale(16'h2000, cdb(5'(k))), fdb(5'(k)));
         check("tx sweep", 32'(ex), 32'(otx));
         ex = scale(scale(16'hdfff, cdb(5'(k))), fdb(5'(k)));
         check("rx sweep", 32'(ex), 32'(orx));
      end
      // Second reset in mid-run clears every setting
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      check("reset tx data", 32'h0, 32'(tx_out_data));
      check("reset rx data", 32'h0, 32'(rx_out_data));
      for (int j = 0; j < 4; j++)
         rdchk("reset reg", addrs[j], 32'h0, 1'b0);
      // Unmapped places answer with an error and leave settings alone
      wr(8'ha8, 5'h0c);
      rdchk("unmapped a8", 8'ha8, 32'h0, 1'b1);
      rdchk("unmapped 00", 8'h00, 32'h0, 1'b1);
      rdchk("tx coarse kept", TX_COARSE_ADDR, 32'h0, 1'b0);
      // Back-to-back samples at unity pass through unchanged
      txq.delete();
      @(posedge mclk);
      tx_in_valid <= 1'b1;
      tx_in_data <= 16'h1111;
      @(posedge mclk);
      tx_in_data <= 16'h8222;
      @(posedge mclk);
      tx_in_valid <= 1'b0;
      repeat (6) @(posedge mclk);
      check("burst count", 32'd2, 32'(txq.size()));
      if (txq.size() == 2) begin
         check("burst 0", 32'h1111, {16'h0, txq[0]});
         check("burst 1", 32'h8222, {16'h0, txq[1]});
      end
      give_verdict;
   end
endmodule : tb_top
